// >>> hdl/branch_and_bit_set_exec.sv
/*
 * Execute logic for two conditional branches, the unconditional branch
 * and the single bit set of an 8-bit core, with an APB register slave.
 * Assumes instruction word, flags, index base and file read data come
 * from logic on ref_clk; file read data is valid one phase after rd.
 */
// The APB register port and the placing of the registers are this design's own decisions.
// Behaviour
// - Opcode e5 with 8-bit offset branches only when overflow is clear.
// - Opcode e1 with 8-bit offset branches only when zero is clear.
// - A taken conditional branch goes to incremented PC plus twice offset.
// - Prefix 11010 with 11-bit offset always goes to PC plus twice offset.
// - The unconditional branch takes two instruction cycles and one word.
// - A conditional branch takes one cycle, or two cycles when taken.
// - A taken branch writes PC in the fourth phase, then idles a cycle.
// - Prefix 1000 sets the indexed bit of the addressed file register.
// - With access flag 0 and no indexing the operand lies in the access bank.
// - With access flag 1 the bank comes from the bank select register.
// - Access flag 0, extension on and address up to 95 use indexing.
`timescale 1ns/1ns
module branch_and_bit_set_exec #(
   parameter int unsigned PC_W      = exec_pkg::PC_W_DEF,
   parameter int unsigned PHASE_DIV = exec_pkg::PHASE_DIV_DEF
) (
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [15:0]                 instr_word,
   input  wire logic                        ovf_flag,
   input  wire logic                        zero_flag,
   input  wire logic [11:0]                 index_base,
   input  wire logic [7:0]                  file_rdata,
   output logic [PC_W-1:0]                  fetch_addr,
   output exec_pkg::file_req_t              file_req,
   output logic                             phase_en,
   output exec_pkg::phase_t                 phase
);
   logic                      run_q;
   logic                      ext_set_q;
   logic [3:0]                bank_select_reg_q;
   logic [PC_W-1:0]           pc_q;
   exec_pkg::exec_state_t     state_q;
   logic [15:0]               ir_q;
   logic [7:0]                rmw_q;
   logic [exec_pkg::TAKEN_W-1:0] taken_cnt_q;
   exec_pkg::op_kind_t        last_kind_q;
   logic                      last_taken_q;
   exec_pkg::op_kind_t        kind;
   logic                      take;
   logic                      indexed;
   logic [11:0]               operand_addr;
   logic [PC_W-1:0]           cond_target;
   logic [PC_W-1:0]           bra_target;
   logic [PC_W-1:0]           target;
   logic                      in_exec;
   logic                      act_q1;
   logic                      act_q2;
   logic                      act_q3;
   logic                      act_q4;
   logic                      apb_wr;
   logic                      pc_wr;
   logic                      taken_clr;
   logic                      hit;
   logic [31:0]               rd_mux;
   logic [7:0]                bit_mask;

   q_phase_gen #(
      .DIV (PHASE_DIV)
   ) u_phase (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .run      (run_q),
      .phase_en (phase_en),
      .phase    (phase)
   );

   assign act_q1  = phase_en && (phase == exec_pkg::q1);
   assign act_q2  = phase_en && (phase == exec_pkg::q2);
   assign act_q3  = phase_en && (phase == exec_pkg::q3);
   assign act_q4  = phase_en && (phase == exec_pkg::q4);
   assign in_exec = (state_q == exec_pkg::exec_st);

   // Opcode matching on the latched instruction word.
   always_comb begin
      kind = exec_pkg::other_op;
      if (ir_q[15:8] == exec_pkg::OP_NO_OVF_HI) begin
         kind = exec_pkg::branch_no_overflow_op;
      end else if (ir_q[15:8] == exec_pkg::OP_NONZERO_HI) begin
         kind = exec_pkg::branch_nonzero_op;
      end else if (ir_q[15:11] == exec_pkg::OP_ALWAYS_HI) begin
         kind = exec_pkg::branch_always_op;
      end else if (ir_q[15:12] == exec_pkg::OP_SETBIT_HI) begin
         kind = exec_pkg::set_file_bit_op;
      end
   end

   // Flags are only read here; this block has no path to write them.
   always_comb begin
      case (kind)
         exec_pkg::branch_no_overflow_op: take = !ovf_flag;
         exec_pkg::branch_nonzero_op:     take = !zero_flag;
         exec_pkg::branch_always_op:      take = 1'b1;
         default:                         take = 1'b0;
      endcase
   end

   // The PC already points past the branch when these are used.
   assign cond_target = pc_q
      + {{(PC_W-9){ir_q[7]}}, ir_q[7:0], 1'b0};
   assign bra_target = pc_q
      + {{(PC_W-12){ir_q[10]}}, ir_q[10:0], 1'b0};
   assign target = (kind == exec_pkg::branch_always_op)
      ? bra_target : cond_target;

   // Operand address selection for the bit set.
   assign indexed = !ir_q[8] && ext_set_q
      && (ir_q[7:0] <= exec_pkg::INDEX_MAX);
   always_comb begin
      if (ir_q[8]) begin
         operand_addr = {bank_select_reg_q, ir_q[7:0]};
      end else if (indexed) begin
         operand_addr = index_base + {4'h0, ir_q[7:0]};
      end else if (ir_q[7:0] >= exec_pkg::ACCESS_SPLIT) begin
         operand_addr = {exec_pkg::ACCESS_HI_BANK, ir_q[7:0]};
      end else begin
         operand_addr = {exec_pkg::ACCESS_LO_BANK, ir_q[7:0]};
      end
   end

   assign bit_mask = 8'h01 << ir_q[11:9];

   // APB slave: zero wait states, read data staged in the setup cycle.
   assign apb_wr    = psel && penable && pwrite;
   assign pc_wr     = apb_wr && (paddr == exec_pkg::REG_PC);
   assign taken_clr = apb_wr && (paddr == exec_pkg::REG_TAKEN);
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !hit;

   always_comb begin
      rd_mux = 32'h0;
      hit    = 1'b1;
      case (paddr)
         exec_pkg::REG_CTRL: begin
            rd_mux[exec_pkg::CTRL_RUN_BIT] = run_q;
            rd_mux[exec_pkg::CTRL_EXT_BIT] = ext_set_q;
         end
         exec_pkg::REG_BANK: begin
            rd_mux[3:0] = bank_select_reg_q;
         end
         exec_pkg::REG_PC: begin
            rd_mux[PC_W-1:0] = pc_q;
         end
         exec_pkg::REG_STATUS: begin
            rd_mux[exec_pkg::ST_PHASE_LSB +: 2] = phase;
            rd_mux[exec_pkg::ST_FLUSH_BIT]      = !in_exec;
            rd_mux[exec_pkg::ST_TAKEN_BIT]      = last_taken_q;
            rd_mux[exec_pkg::ST_KIND_LSB +: 3]  = last_kind_q;
         end
         exec_pkg::REG_TAKEN: begin
            rd_mux[exec_pkg::TAKEN_W-1:0] = taken_cnt_q;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_q             <= exec_pkg::RUN_RST;
         ext_set_q         <= exec_pkg::EXT_RST;
         bank_select_reg_q <= exec_pkg::BANK_RST;
      end else if (apb_wr && paddr == exec_pkg::REG_CTRL) begin
         run_q     <= pwdata[exec_pkg::CTRL_RUN_BIT];
         ext_set_q <= pwdata[exec_pkg::CTRL_EXT_BIT];
      end else if (apb_wr && paddr == exec_pkg::REG_BANK) begin
         bank_select_reg_q <= pwdata[3:0];
      end
   end

   // Program counter: step in the first phase, branch in the fourth.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pc_q <= '0;
      end else if (pc_wr) begin
         pc_q <= {pwdata[PC_W-1:1], 1'b0};
      end else if (act_q1 && in_exec) begin
         pc_q <= pc_q + PC_W'(2);
      end else if (act_q4 && in_exec && take) begin
         pc_q <= target;
      end
   end

   assign fetch_addr = pc_q;

   // A taken branch spends the following instruction cycle idle.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= exec_pkg::exec_st;
      end else if (pc_wr) begin
         state_q <= exec_pkg::exec_st;
      end else if (act_q4) begin
         case (state_q)
            exec_pkg::exec_st: begin
               if (take) begin
                  state_q <= exec_pkg::flush_st;
               end
            end
            exec_pkg::flush_st: begin
               state_q <= exec_pkg::exec_st;
            end
            default: begin
               state_q <= exec_pkg::exec_st;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ir_q <= exec_pkg::NOP_WORD;
      end else if (act_q1) begin
         ir_q <= in_exec ? instr_word : exec_pkg::NOP_WORD;
      end
   end

   // Bit set as read, modify, write across the instruction cycle.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         file_req <= '0;
         rmw_q    <= 8'h00;
      end else begin
         file_req.rd <= 1'b0;
         file_req.wr <= 1'b0;
         if (in_exec && kind == exec_pkg::set_file_bit_op) begin
            if (act_q2) begin
               file_req.rd   <= 1'b1;
               file_req.addr <= operand_addr;
            end
            if (act_q3) begin
               rmw_q <= file_rdata | bit_mask;
            end
            if (act_q4) begin
               file_req.wr    <= 1'b1;
               file_req.wdata <= rmw_q;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         taken_cnt_q  <= '0;
         last_kind_q  <= exec_pkg::other_op;
         last_taken_q <= 1'b0;
      end else begin
         if (act_q4 && in_exec) begin
            last_kind_q  <= kind;
            last_taken_q <= take;
         end
         // A taken branch in the clearing cycle is still counted.
         if (act_q4 && in_exec && take) begin
            taken_cnt_q <= taken_clr ? exec_pkg::TAKEN_W'(1)
                                     : taken_cnt_q + exec_pkg::TAKEN_W'(1);
         end else if (taken_clr) begin
            taken_cnt_q <= '0;
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   property p_nov_taken;
      act_q4 && in_exec && kind == exec_pkg::branch_no_overflow_op
         && !ovf_flag && !pc_wr
      |=> state_q == exec_pkg::flush_st && pc_q == $past(cond_target);
   endproperty
   a_nov_taken: assert property (p_nov_taken)
      else $error("overflow-clear branch not taken");

   property p_nov_held;
      act_q4 && in_exec && kind == exec_pkg::branch_no_overflow_op
         && ovf_flag && !pc_wr
      |=> state_q == exec_pkg::exec_st && $stable(pc_q);
   endproperty
   a_nov_held: assert property (p_nov_held)
      else $error("overflow-set branch was taken");

   property p_nz;
      act_q4 && in_exec && kind == exec_pkg::branch_nonzero_op && !pc_wr
      |=> (state_q == exec_pkg::flush_st) == !$past(zero_flag);
   endproperty
   a_nz: assert property (p_nz)
      else $error("nonzero branch decision wrong");

   property p_cond_target;
      act_q4 && in_exec && !pc_wr
         && kind == exec_pkg::branch_nonzero_op && !zero_flag
      |=> pc_q == $past(pc_q)
         + {{(PC_W-9){$past(ir_q[7])}}, $past(ir_q[7:0]), 1'b0};
   endproperty
   a_cond_target: assert property (p_cond_target)
      else $error("conditional branch target wrong");

   property p_bra;
      act_q4 && in_exec && ir_q[15:11] == 5'h1a && !pc_wr
      |=> state_q == exec_pkg::flush_st && pc_q == $past(bra_target);
   endproperty
   a_bra: assert property (p_bra)
      else $error("unconditional branch not taken");

   property p_flush_one_cycle;
      act_q4 && state_q == exec_pkg::flush_st && !pc_wr
      |=> state_q == exec_pkg::exec_st;
   endproperty
   a_flush_one_cycle: assert property (p_flush_one_cycle)
      else $error("idle cycle after branch not one cycle");

   property p_flush_idle;
      act_q1 && state_q == exec_pkg::flush_st && !pc_wr
      |=> $stable(pc_q) && ir_q == exec_pkg::NOP_WORD && !file_req.rd;
   endproperty
   a_flush_idle: assert property (p_flush_idle)
      else $error("work done in idle cycle");

   property p_setbit;
      act_q3 && in_exec && kind == exec_pkg::set_file_bit_op
      |=> rmw_q == ($past(file_rdata) | (8'h01 << $past(ir_q[11:9])));
   endproperty
   a_setbit: assert property (p_setbit)
      else $error("bit set value wrong");

   property p_access_bank;
      act_q2 && in_exec && kind == exec_pkg::set_file_bit_op
         && !ir_q[8] && !indexed
      |=> file_req.rd && file_req.addr[7:0] == $past(ir_q[7:0])
         && file_req.addr[11:8]
            == (($past(ir_q[7:0]) >= exec_pkg::ACCESS_SPLIT)
               ? exec_pkg::ACCESS_HI_BANK : exec_pkg::ACCESS_LO_BANK);
   endproperty
   a_access_bank: assert property (p_access_bank)
      else $error("access bank address wrong");

   property p_bank_reg;
      act_q2 && in_exec && kind == exec_pkg::set_file_bit_op && ir_q[8]
      |=> file_req.addr == {$past(bank_select_reg_q), $past(ir_q[7:0])};
   endproperty
   a_bank_reg: assert property (p_bank_reg)
      else $error("banked address wrong");

   property p_indexed;
      act_q2 && in_exec && kind == exec_pkg::set_file_bit_op
         && !ir_q[8] && ext_set_q && ir_q[7:0] < 8'h60
      |=> file_req.addr == $past(index_base) + {4'h0, $past(ir_q[7:0])};
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed address wrong");

   property p_writeback;
      act_q4 && in_exec && kind == exec_pkg::set_file_bit_op
      |=> file_req.wr && file_req.wdata == $past(rmw_q) && !file_req.rd;
   endproperty
   a_writeback: assert property (p_writeback)
      else $error("write back missing in fourth phase");

   c_nov_taken: cover property (act_q4 && in_exec && take
      && kind == exec_pkg::branch_no_overflow_op);
   c_bra: cover property (act_q4 && in_exec
      && kind == exec_pkg::branch_always_op);
   c_setbit_wr: cover property (file_req.wr && file_req.addr[11:8] == 4'hf);

endmodule : branch_and_bit_set_exec

// >>> common/exec_pkg.sv
/*
 * Shared constants and types for the branch and bit-set execute block:
 * opcode patterns, bank and index addressing limits, register offsets,
 * field positions, reset values, phase and state encodings.
 * Assumes a 16-bit instruction word and a 12-bit file address space.
 */
package exec_pkg;

   localparam int unsigned PC_W_DEF      = 16;
   localparam int unsigned PHASE_DIV_DEF = 1;
   localparam int unsigned INSTR_W       = 16;
   localparam int unsigned FILE_ADDR_W   = 12;
   localparam int unsigned BANK_W        = 4;
   localparam int unsigned TAKEN_W       = 16;

   localparam logic [7:0]  OP_NO_OVF_HI  = 8'he5;
   localparam logic [7:0]  OP_NONZERO_HI = 8'he1;
   localparam logic [4:0]  OP_ALWAYS_HI  = 5'h1a;
   localparam logic [3:0]  OP_SETBIT_HI  = 4'h8;
   localparam logic [15:0] NOP_WORD      = 16'h0000;

   localparam logic [7:0]  INDEX_MAX      = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
   localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;

   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_BANK   = 8'h04;
   localparam logic [7:0]  REG_PC     = 8'h08;
   localparam logic [7:0]  REG_STATUS = 8'h0c;
   localparam logic [7:0]  REG_TAKEN  = 8'h10;

   localparam int unsigned CTRL_RUN_BIT   = 0;
   localparam int unsigned CTRL_EXT_BIT   = 1;
   localparam int unsigned ST_PHASE_LSB   = 0;
   localparam int unsigned ST_FLUSH_BIT   = 2;
   localparam int unsigned ST_TAKEN_BIT   = 3;
   localparam int unsigned ST_KIND_LSB    = 4;

   localparam logic        RUN_RST  = 1'b0;
   localparam logic        EXT_RST  = 1'b0;
   localparam logic [3:0]  BANK_RST = 4'h0;

   typedef enum logic [1:0] {
      q1 = 2'b00, q2 = 2'b01, q3 = 2'b10, q4 = 2'b11
   } phase_t;

   typedef enum logic {
      exec_st = 1'b0, flush_st = 1'b1
   } exec_state_t;

   typedef enum logic [2:0] {
      other_op              = 3'b000,
      branch_no_overflow_op = 3'b001,
      branch_nonzero_op     = 3'b010,
      branch_always_op      = 3'b011,
      set_file_bit_op       = 3'b100
   } op_kind_t;

   typedef struct packed {
      logic                   rd;
      logic                   wr;
      logic [FILE_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
   } file_req_t;

endpackage : exec_pkg

// >>> hdl/q_phase_gen.sv
/*
 * Quadrature phase generator: divides ref_clk into phase enables and
 * steps through the four phases of an instruction cycle.
 * Assumes run comes from logic on the same clock.
 */
`timescale 1ns/1ns
module q_phase_gen #(
   parameter int unsigned DIV = exec_pkg::PHASE_DIV_DEF
) (
   input  wire logic      ref_clk,
   input  wire logic      nrst,
   input  wire logic      run,
   output logic           phase_en,
   output exec_pkg::phase_t phase
);
   localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);

   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (!run || cnt_q == CNT_LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   assign phase_en = run && (cnt_q == CNT_LAST);

   // The phase freezes while stopped so a halted cycle resumes in place.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         phase <= exec_pkg::q1;
      end else if (phase_en) begin
         phase <= exec_pkg::phase_t'(phase + 2'h1);
      end
   end

endmodule : q_phase_gen

// >>> sim/branch_and_bit_set_exec_tb_top.sv
/*
 * Self-checking bench for the branch and bit-set execute block: random
 * programs run against a cycle model, registers are checked over APB.
 * Assumes the package and the design files are compiled before it.
 */
`timescale 1ns/1ns
module branch_and_bit_set_exec_tb_top;
   logic                ref_clk    = 1'b0;
   logic                nrst       = 1'b0;
   logic                psel       = 1'b0;
   logic                penable    = 1'b0;
   logic                pwrite     = 1'b0;
   logic [7:0]          paddr      = 8'h00;
   logic [31:0]         pwdata     = 32'h0;
   logic [15:0]         instr_word = 16'h0000;
   logic                ovf_flag   = 1'b0;
   logic                zero_flag  = 1'b0;
   logic [11:0]         index_base = 12'h000;
   logic [7:0]          file_rdata = 8'h00;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [15:0]         fetch_addr;
   logic                phase_en;
   exec_pkg::file_req_t file_req;
   exec_pkg::phase_t    phase;
   logic [15:0]         prog [0:255];
   integer              seed      = 32'h0ba9;
   int                  n_fail    = 0;
   int                  tests_run = 0;
   int                  taken_m   = 0;
   logic                run_m     = 1'b0;
   logic                ext_m     = 1'b0;
   logic [3:0]          bank_m    = 4'h0;
   logic                idle_m, exp_rd, exp_wr, tk, re;
   logic [1:0]          ph_m;
   logic [15:0]         pc_m, ir_m, off;
   logic [11:0]         a_m;
   logic [7:0]          rdat_m, wdat_m;
   logic [31:0]         rv;

   branch_and_bit_set_exec u_dut (
      .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_word(instr_word),
      .ovf_flag(ovf_flag), .zero_flag(zero_flag),
      .index_base(index_base), .file_rdata(file_rdata),
      .fetch_addr(fetch_addr), .file_req(file_req),
      .phase_en(phase_en), .phase(phase));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // Program memory answers the fetch address; flags and data are random.
   always @(posedge ref_clk) begin
      ovf_flag   <= 1'($random(seed));
      zero_flag  <= 1'($random(seed));
      index_base <= 12'($random(seed));
      file_rdata <= 8'($random(seed));
      instr_word <= prog[fetch_addr[8:1]];
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   function automatic logic [15:0] gen_word();
      logic [15:0] r;
      r = 16'($random(seed));
      case (r[15:14])
         2'd0: gen_word = {exec_pkg::OP_NO_OVF_HI, r[7:0]};
         2'd1: gen_word = {exec_pkg::OP_NONZERO_HI, r[7:0]};
         2'd2: gen_word = {exec_pkg::OP_ALWAYS_HI, r[10:0]};
         default: gen_word = {exec_pkg::OP_SETBIT_HI, r[11:0]};
      endcase
   endfunction : gen_word

   // Cycle model: expectations made at one edge are compared at the next.
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ph_m    = 2'd0;
         pc_m    = 16'h0000;
         idle_m  = 1'b0;
         exp_rd  = 1'b0;
         exp_wr  = 1'b0;
         ir_m    = exec_pkg::NOP_WORD;
         taken_m = 0;
      end else begin
         chk_bit(file_req.rd, exp_rd);
         chk_bit(file_req.wr, exp_wr);
         if (exp_rd)
            chk_val(32'(file_req.addr), 32'(a_m));
         if (exp_wr)
            chk_val({file_req.addr, 12'h0, file_req.wdata},
                    {a_m, 12'h0, wdat_m});
         exp_rd = 1'b0;
         exp_wr = 1'b0;
         chk_bit(phase_en, run_m);
         if (phase_en === 1'b1) begin
            chk_val(32'(phase), 32'(ph_m));
            case (ph_m)
               2'd0: begin
                  chk_val(32'(fetch_addr), 32'(pc_m));
                  ir_m = idle_m ? exec_pkg::NOP_WORD : instr_word;
                  if (!idle_m)
                     pc_m = pc_m + 16'h0002;
               end
               2'd1: if (ir_m[15:12] == exec_pkg::OP_SETBIT_HI) begin
                  if (ir_m[8])
                     a_m = {bank_m, ir_m[7:0]};
                  else if (ext_m && ir_m[7:0] <= exec_pkg::INDEX_MAX)
                     a_m = index_base + {4'h0, ir_m[7:0]};
                  else if (ir_m[7:0] < exec_pkg::ACCESS_SPLIT)
                     a_m = {exec_pkg::ACCESS_LO_BANK, ir_m[7:0]};
                  else
                     a_m = {exec_pkg::ACCESS_HI_BANK, ir_m[7:0]};
                  exp_rd = 1'b1;
               end
               2'd2: rdat_m = file_rdata;
               default: begin
                  tk = (ir_m[15:11] == exec_pkg::OP_ALWAYS_HI) ||
                       (ir_m[15:8] == exec_pkg::OP_NO_OVF_HI && !ovf_flag) ||
                       (ir_m[15:8] == exec_pkg::OP_NONZERO_HI && !zero_flag);
                  off = (ir_m[15:11] == exec_pkg::OP_ALWAYS_HI) ?
                        {{4{ir_m[10]}}, ir_m[10:0], 1'b0} :
                        {{7{ir_m[7]}}, ir_m[7:0], 1'b0};
                  if (idle_m)
                     idle_m = 1'b0;
                  else if (tk) begin
                     pc_m    = pc_m + off;
                     idle_m  = 1'b1;
                     taken_m = taken_m + 1;
                  end
                  if (ir_m[15:12] == exec_pkg::OP_SETBIT_HI) begin
                     wdat_m = rdat_m | (8'h01 << ir_m[11:9]);
                     exp_wr = 1'b1;
                  end
               end
            endcase
            ph_m = ph_m + 2'd1;
         end
      end
   end

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
      int i;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 64);
      if (i < 64) begin
         q   = prdata;
         err = pslverr;
         if (wr && a == exec_pkg::REG_CTRL) begin
            run_m <= d[0];
            ext_m <= d[1];
         end
         if (wr && a == exec_pkg::REG_BANK)
            bank_m <= d[3:0];
         if (wr && a == exec_pkg::REG_PC)
            pc_m <= d[15:0] & 16'hfffe;
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge ref_clk);
      end else begin
         n_fail++;
         end_sim();
      end
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic exp_err);
      apb(1'b0, a, 32'h0, rv, re);
      chk_val(rv, exp);
      chk_bit(re, exp_err);
   endtask : rd_chk

   initial begin
      for (int k = 0; k < 256; k++)
         prog[k] = gen_word();
      prog[128] = 16'h8e5f;
      prog[129] = 16'h8060;
      prog[130] = 16'h8712;
      prog[131] = 16'he580;
      prog[132] = 16'he17f;
      prog[200] = 16'hd400;
      prog[201] = 16'hd3ff;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rd_chk(exec_pkg::REG_CTRL, 32'h0, 1'b0);
      rd_chk(exec_pkg::REG_BANK, 32'h0, 1'b0);
      rd_chk(exec_pkg::REG_PC, 32'h0, 1'b0);
      rd_chk(exec_pkg::REG_STATUS, 32'h0, 1'b0);
      rd_chk(exec_pkg::REG_TAKEN, 32'h0, 1'b0);
      rd_chk(8'h20, 32'h0, 1'b1);
      apb(1'b1, exec_pkg::REG_STATUS, 32'hffffffff, rv, re);
      rd_chk(exec_pkg::REG_STATUS, 32'h0, 1'b0);
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, exec_pkg::REG_BANK, $random(seed), rv, re);
         rd_chk(exec_pkg::REG_BANK, {28'h0, bank_m}, 1'b0);
         apb(1'b1, exec_pkg::REG_PC, 32'h00000101, rv, re);
         rd_chk(exec_pkg::REG_PC, 32'h00000100, 1'b0);
         apb(1'b1, exec_pkg::REG_CTRL, {30'h0, p[0], 1'b1}, rv, re);
         repeat (3000) @(posedge ref_clk);
         apb(1'b1, exec_pkg::REG_CTRL, 32'h0, rv, re);
         rd_chk(exec_pkg::REG_TAKEN, 32'(taken_m), 1'b0);
         apb(1'b1, exec_pkg::REG_TAKEN, 32'h5, rv, re);
         rd_chk(exec_pkg::REG_TAKEN, 32'h0, 1'b0);
         // Reset lands in mid-instruction to check a clean restart.
         apb(1'b1, exec_pkg::REG_CTRL, 32'h1, rv, re);
         repeat (37) @(posedge ref_clk);
         nrst   <= 1'b0;
         run_m  <= 1'b0;
         ext_m  <= 1'b0;
         bank_m <= 4'h0;
         repeat (12) @(posedge ref_clk);
         nrst <= 1'b1;
         @(posedge ref_clk);
      end
      end_sim();
   end
endmodule : branch_and_bit_set_exec_tb_top
